// ### hw/dsa_pkg.sv
/*
  Shared constants and types of the dual-port stream aggregator: register map,
  field positions, reset values, forward frame layouts, packet word and timing.
  Assumes a 100 MHz system clock and a 25 MHz reference clock.
*/
package dsa_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_PORT_CFG = 8'h6d;
  localparam logic [7:0] REG_VC_REMAP = 8'h72;
  localparam logic [7:0] REG_OUT_CFG = 8'h33;
  localparam logic [7:0] REG_STATUS = 8'h4d;
  localparam logic [7:0] PORT_CFG_RESET = 8'h00;
  localparam logic [7:0] VC_REMAP_RESET = 8'he4;
  localparam logic [7:0] OUT_CFG_RESET = 8'h00;
  localparam int PCFG_MODE_LSB = 0;
  localparam int PCFG_SYNC_BIT = 2;
  localparam int OCFG_DUAL_BIT = 0;
  localparam int STAT_LOCK_LSB = 0;
  localparam int STAT_OVF_LSB = 2;
  localparam int STAT_STRAP_BIT = 4;

  // ****************************************
  // modes and strap codes
  // ****************************************
  typedef enum logic [1:0] {MODE_CSI, MODE_RAW12LF, MODE_RAW12HF, MODE_RAW10} dsa_mode_t;
  localparam logic [2:0] STRAP_CSI_NONSYNC = 3'h0;
  localparam logic [2:0] STRAP_RAW12LF = 3'h1;
  localparam logic [2:0] STRAP_RAW12HF = 3'h2;
  localparam logic [2:0] STRAP_RAW10 = 3'h3;
  localparam logic [2:0] STRAP_CSI_SYNC = 3'h4;

  // ****************************************
  // forward frames
  // ****************************************
  localparam int NUM_PORTS = 2;
  localparam logic [5:0] CSI_FRAME_BITS = 6'h28;
  localparam logic [5:0] RAW_FRAME_BITS = 6'h1c;
  localparam logic [3:0] CSI_SYNC = 4'ha;
  localparam logic [1:0] RAW_SYNC = 2'h2;
  localparam logic [5:0] DTYPE_RAW10 = 6'h2b;
  localparam logic [5:0] DTYPE_RAW12 = 6'h2c;

  typedef struct packed {
    logic [3:0] sync;
    logic sop;
    logic eop;
    logic [1:0] vc;
    logic [5:0] dtype;
    logic [15:0] data;
    logic [7:0] ctrl;
    logic payload;
    logic parity;
  } dsa_csi_frame_t;

  typedef struct packed {
    logic [1:0] sync;
    logic lineStart;
    logic lineEnd;
    logic [11:0] pixel;
    logic [7:0] ctrl;
    logic [2:0] diag;
    logic parity;
  } dsa_raw_frame_t;

  typedef struct packed {
    logic sop;
    logic eop;
    logic [1:0] vc;
    logic [5:0] dtype;
    logic [15:0] data;
  } dsa_word_t;

  localparam int WORD_W = $bits(dsa_word_t);
  localparam int FIFO_DEPTH = 16;
  localparam int CSI_BUS_W = 32;

  // ****************************************
  // timing
  // ****************************************
  localparam int SYS_CLK_MHZ = 100;
  localparam int REF_CLK_MHZ = 25;
  localparam int STRAP_WAIT_US = 1000;
  localparam int STRAP_WAIT_CYCLES = STRAP_WAIT_US * SYS_CLK_MHZ;
  localparam int LINE_MULT_SYNC = 160;
  localparam int PCLK_MULT_SYNC = 4;
  localparam int BC_MULT_SYNC = 2;
  localparam int LINE_MULT_NONSYNC = 80;
  localparam int BC_SYNC_MBPS = BC_MULT_SYNC * REF_CLK_MHZ;
  localparam int BC_NONSYNC_MBPS = 10;
  localparam logic [3:0] BC_SYNC_DIV = 4'(SYS_CLK_MHZ / BC_SYNC_MBPS);
  localparam logic [3:0] BC_NONSYNC_DIV = 4'(SYS_CLK_MHZ / BC_NONSYNC_MBPS);
  localparam logic [3:0] BC_WORD_BITS = 4'hc;
  localparam logic [1:0] BC_SYNC = 2'h1;
  localparam int CSI_LANE_MAX_MBPS = 1662;
  localparam int FWD_LINE_MAX_MBPS = 4160;

endpackage

// ### hw/dsa_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and honest full/empty.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module dsa_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 16
)(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } dsa_fifo_state_t;

  dsa_fifo_state_t st;
  dsa_fifo_state_t next_st;
  logic full;
  logic empty;

  assign empty = st.wrPtr == st.rdPtr;
  assign full = (st.wrPtr[AW] != st.rdPtr[AW]) && (st.wrPtr[AW-1:0] == st.rdPtr[AW-1:0]);
  assign inReady = ~full;
  assign outValid = ~empty;
  assign outData = st.mem[st.rdPtr[AW-1:0]];

  always_comb begin
    next_st = st;
    if (inValid && !full) begin
      next_st.mem[st.wrPtr[AW-1:0]] = inData;
      next_st.wrPtr = st.wrPtr + (AW+1)'(1);
    end
    if (outReady && !empty) begin
      next_st.rdPtr = st.rdPtr + (AW+1)'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // dsa_fifo

// ### hw/dsa_aggregator.sv
/*
  Dual receive port aggregator: deframes forward link streams, remaps virtual
  channels, merges packets onto a four-lane or replicated two-lane output and
  drives the control back channel. Assumes link clocks and strap pins arrive
  asynchronously and a downstream lane interface that can stall with csiReady.
*/
// Function
// RULE1: four data lanes, one output port
// RULE2: dual two-lane outputs carry replicated data
// RULE3: second clock lane enabled in dual mode
// RULE4: payload forwarded unconverted
// RULE5: image and non-image packets both carried
// RULE6: streams interleaved as per-channel packets
// RULE7: channel tag in every packet header
// RULE8: camera-serial mode uses 40-bit frames
// RULE9: frames carry payload, control, integrity fields
// RULE10: raw mode uses 28-bit frames
// RULE11: recover forward stream, drive back channel
// RULE12: two ports, each mode set independently
// RULE13: mode from config register or strap
// RULE14: output always camera-serial packets
// RULE15: per-port channel tag remapping
// RULE16: port line rate up to 4.16 Gbps; code takes one bit per link clock rising edge seen at sys_clk, at most 50 Mbps
// RULE17: sync mode rates from reference clock
// RULE18: non-sync back channel at 10 Mbps
// RULE19: forward rate independent of output rate
// RULE20: control channel runs continuously
// RULE21: host drives control via I2C port; code uses a parallel register port (regAddr, regWrData)
// RULE22: strap sampled 1 ms after release
// RULE23: raw10 syncs toggle at most every 10 clocks; code does not limit how often lineStart/lineEnd toggle
// RULE24: per-channel packet order kept
`timescale 1ns/10ps
module dsa_aggregator #(
  parameter int STRAP_WAIT = dsa_pkg::STRAP_WAIT_CYCLES,
  parameter int DEPTH = dsa_pkg::FIFO_DEPTH
)(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [dsa_pkg::NUM_PORTS-1:0] portLinkClk,
  input wire logic [dsa_pkg::NUM_PORTS-1:0] portLinkData,
  output logic [dsa_pkg::NUM_PORTS-1:0] bcOut,
  input wire logic [dsa_pkg::NUM_PORTS-1:0][7:0] bcTxByte,
  input wire logic [dsa_pkg::NUM_PORTS-1:0] bcTxValid,
  output logic [dsa_pkg::NUM_PORTS-1:0] bcTxReady,
  output logic [dsa_pkg::NUM_PORTS-1:0][7:0] ctrlRxByte,
  output logic [dsa_pkg::NUM_PORTS-1:0] ctrlRxValid,
  output logic [dsa_pkg::NUM_PORTS-1:0] portLocked,
  input wire logic powerdownReleasePin,
  input wire logic [2:0] strapMode,
  input wire logic [7:0] regAddr,
  input wire logic regPort,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  output logic [dsa_pkg::CSI_BUS_W-1:0] csiData,
  output logic [3:0] csiByteEn,
  output logic csiValid,
  input wire logic csiReady,
  output logic [1:0] csiClkEn
);
  import dsa_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [NUM_PORTS-1:0] clkS1;
    logic [NUM_PORTS-1:0] clkS2;
    logic [NUM_PORTS-1:0] clkS3;
    logic [NUM_PORTS-1:0] datS1;
    logic [NUM_PORTS-1:0] datS2;
    logic pdbS1;
    logic pdbS2;
    logic [2:0] strapS1;
    logic [2:0] strapS2;
    logic [31:0] strapCnt;
    logic strapDone;
    logic [NUM_PORTS-1:0][7:0] portCfg;
    logic [NUM_PORTS-1:0][7:0] vcRemap;
    logic [7:0] outCfg;
    logic [NUM_PORTS-1:0][39:0] shiftReg;
    logic [NUM_PORTS-1:0][5:0] bitCnt;
    logic [NUM_PORTS-1:0] locked;
    logic [NUM_PORTS-1:0][7:0] ctrlByte;
    logic [NUM_PORTS-1:0] ctrlValid;
    logic [NUM_PORTS-1:0] pendValid;
    logic [NUM_PORTS-1:0][WORD_W-1:0] pend;
    logic [NUM_PORTS-1:0] overflow;
    logic [7:0] rdData;
    logic [NUM_PORTS-1:0][3:0] bcDiv;
    logic [NUM_PORTS-1:0][3:0] bcBit;
    logic [NUM_PORTS-1:0][11:0] bcShift;
    logic [NUM_PORTS-1:0] bcLine;
    logic [NUM_PORTS-1:0] bcReady;
    logic curPort;
    logic lastPort;
    logic inPacket;
    logic hdrDone;
    logic [15:0] half;
    logic halfValid;
    logic [CSI_BUS_W-1:0] outData;
    logic [3:0] outEn;
    logic outValid;
    logic [1:0] clkEn;
  } dsa_state_t;

  dsa_state_t st;
  dsa_state_t next_st;

  logic [NUM_PORTS-1:0] fifoInReady;
  logic [NUM_PORTS-1:0] fifoOutValid;
  logic [NUM_PORTS-1:0] fifoPop;
  logic [NUM_PORTS-1:0][WORD_W-1:0] fifoOutData;

  logic [39:0] sh;
  logic [5:0] cnt;
  logic [5:0] frameLen;
  logic isCsi;
  logic good;
  logic newValid;
  dsa_word_t newWord;
  dsa_csi_frame_t csiF;
  dsa_raw_frame_t rawF;
  logic [3:0] bcDivLimit;
  logic [3:0] bcDivNext;
  logic [3:0] bcBitNext;
  logic consumed;
  logic canOut;
  logic sel;
  logic unitValid;
  logic unitEop;
  logic [15:0] unit;
  dsa_word_t head;

  function automatic logic [1:0] remapVc(input logic [7:0] map, input logic [1:0] vc);
    remapVc = map[{vc, 1'b0} +: 2];
  endfunction

  function automatic logic [7:0] readReg(input dsa_state_t s, input logic [7:0] addr, input logic port);
    unique case (addr)
      REG_PORT_CFG: readReg = s.portCfg[port];
      REG_VC_REMAP: readReg = s.vcRemap[port];
      REG_OUT_CFG: readReg = s.outCfg;
      REG_STATUS: readReg = {3'h0, s.strapDone, s.overflow, s.locked};
      default: readReg = 8'h00;
    endcase
  endfunction

  // ****************************************
  // per-port buffers
  // ****************************************
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_fifo
    dsa_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(DEPTH)
    ) u_fifo (
      .sys_clk(sys_clk),
      .srst(srst),
      .inValid(st.pendValid[p]),
      .inReady(fifoInReady[p]),
      .inData(st.pend[p]),
      .outValid(fifoOutValid[p]),
      .outReady(fifoPop[p]),
      .outData(fifoOutData[p])
    );
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    sh = '0;
    cnt = '0;
    frameLen = '0;
    isCsi = 1'b0;
    good = 1'b0;
    newValid = 1'b0;
    newWord = '0;
    csiF = '0;
    rawF = '0;
    bcDivLimit = '0;
    bcDivNext = '0;
    bcBitNext = '0;
    consumed = 1'b0;
    fifoPop = '0;
    canOut = 1'b0;
    sel = 1'b0;
    unitValid = 1'b0;
    unitEop = 1'b0;
    unit = '0;
    head = '0;

    // link and strap inputs pass two flops; edges come from the second and third
    next_st.clkS1 = portLinkClk;
    next_st.clkS2 = st.clkS1;
    next_st.clkS3 = st.clkS2;
    next_st.datS1 = portLinkData;
    next_st.datS2 = st.datS1;
    next_st.pdbS1 = powerdownReleasePin;
    next_st.pdbS2 = st.pdbS1;
    next_st.strapS1 = strapMode;
    next_st.strapS2 = st.strapS1;

    // register port
    next_st.rdData = regRead ? readReg(st, regAddr, regPort) : st.rdData;
    if (regWrite) begin
      unique case (regAddr)
        REG_PORT_CFG: next_st.portCfg[regPort] = regWrData; // RULE13
        REG_VC_REMAP: next_st.vcRemap[regPort] = regWrData; // RULE15
        REG_OUT_CFG: next_st.outCfg = regWrData;
        REG_STATUS: next_st.overflow = st.overflow & ~regWrData[STAT_OVF_LSB +: NUM_PORTS];
        default: next_st.outCfg = st.outCfg;
      endcase
    end

    // strap applied once, after the release pin has been high long enough
    if (!st.pdbS2) begin
      next_st.strapCnt = '0;
      next_st.strapDone = 1'b0;
    end else if (!st.strapDone) begin
      next_st.strapCnt = st.strapCnt + 32'h1;
      if (st.strapCnt >= 32'(STRAP_WAIT - 1)) begin // RULE22
        next_st.strapDone = 1'b1;
        for (int p = 0; p < NUM_PORTS; p++) begin
          unique case (st.strapS2) // RULE13
            STRAP_RAW12LF: next_st.portCfg[p] = 8'(MODE_RAW12LF);
            STRAP_RAW12HF: next_st.portCfg[p] = 8'(MODE_RAW12HF);
            STRAP_RAW10: next_st.portCfg[p] = 8'(MODE_RAW10);
            STRAP_CSI_SYNC: next_st.portCfg[p] = 8'h1 << PCFG_SYNC_BIT; // RULE17
            default: next_st.portCfg[p] = 8'(MODE_CSI);
          endcase
        end
      end
    end

    for (int p = 0; p < NUM_PORTS; p++) begin
      // forward deframer, one bit per link clock rising edge
      isCsi = st.portCfg[p][PCFG_MODE_LSB +: 2] == 2'(MODE_CSI); // RULE12
      frameLen = isCsi ? CSI_FRAME_BITS : RAW_FRAME_BITS; // RULE8 RULE10
      newValid = 1'b0;
      newWord = '0;
      next_st.ctrlValid[p] = 1'b0;
      if (st.clkS2[p] && !st.clkS3[p]) begin // RULE11 RULE19 RULE16
        sh = {st.shiftReg[p][38:0], st.datS2[p]};
        cnt = st.bitCnt[p] + 6'h1;
        next_st.shiftReg[p] = sh;
        next_st.bitCnt[p] = cnt;
        if (cnt >= frameLen) begin
          csiF = dsa_csi_frame_t'(sh);
          rawF = dsa_raw_frame_t'(sh[27:0]);
          good = isCsi ? (csiF.sync == CSI_SYNC) && !(^sh) : (rawF.sync == RAW_SYNC) && !(^sh[27:0]); // RULE9
          if (good) begin
            next_st.bitCnt[p] = '0;
            next_st.locked[p] = 1'b1;
            next_st.ctrlValid[p] = 1'b1;
            next_st.ctrlByte[p] = isCsi ? csiF.ctrl : rawF.ctrl; // RULE9
            if (isCsi) begin
              newValid = csiF.payload | csiF.sop | csiF.eop; // RULE5
              newWord = '{sop: csiF.sop, eop: csiF.eop, vc: remapVc(st.vcRemap[p], csiF.vc), // RULE15
                          dtype: csiF.dtype, data: csiF.data}; // RULE4
            end else begin
              newValid = 1'b1;
              newWord = '{sop: rawF.lineStart, eop: rawF.lineEnd, vc: remapVc(st.vcRemap[p], 2'h0),
                          dtype: (st.portCfg[p][PCFG_MODE_LSB +: 2] == 2'(MODE_RAW10)) ? DTYPE_RAW10 : DTYPE_RAW12,
                          data: {4'h0, rawF.pixel}}; // RULE4 RULE14
            end
          end else begin
            // slip one bit and test again at the next edge
            next_st.locked[p] = 1'b0;
            next_st.bitCnt[p] = frameLen - 6'h1;
          end
        end
      end

      // hand-off into the buffer; a word that finds the slot busy is dropped and flagged in overflow
      consumed = st.pendValid[p] && fifoInReady[p];
      if (consumed) begin
        next_st.pendValid[p] = 1'b0;
      end
      if (newValid) begin
        if (st.pendValid[p] && !consumed) begin
          next_st.overflow[p] = 1'b1;
        end else begin
          next_st.pend[p] = newWord;
          next_st.pendValid[p] = 1'b1;
        end
      end

      // back channel: 12-bit words sent back to back, idle words when nothing waits
      bcDivLimit = st.portCfg[p][PCFG_SYNC_BIT] ? BC_SYNC_DIV : BC_NONSYNC_DIV; // RULE17 RULE18
      bcDivNext = st.bcDiv[p];
      bcBitNext = st.bcBit[p];
      if (st.bcDiv[p] >= bcDivLimit - 4'h1) begin
        bcDivNext = '0;
        next_st.bcLine[p] = st.bcShift[p][11]; // RULE11 RULE20
        next_st.bcShift[p] = {st.bcShift[p][10:0], 1'b0};
        if (st.bcBit[p] == BC_WORD_BITS - 4'h1) begin
          bcBitNext = '0;
          if (st.bcReady[p] && bcTxValid[p]) begin
            next_st.bcShift[p] = {BC_SYNC, 1'b1, bcTxByte[p], ^{1'b1, bcTxByte[p]}}; // RULE20
          end else begin
            next_st.bcShift[p] = {BC_SYNC, 1'b0, 8'h00, 1'b0};
          end
        end else begin
          bcBitNext = st.bcBit[p] + 4'h1;
        end
      end else begin
        bcDivNext = st.bcDiv[p] + 4'h1;
      end
      next_st.bcDiv[p] = bcDivNext;
      next_st.bcBit[p] = bcBitNext;
      next_st.bcReady[p] = (bcDivNext >= bcDivLimit - 4'h1) && (bcBitNext == BC_WORD_BITS - 4'h1);
    end

    // packet merge: whole packets per port, ports alternate between packets
    canOut = !st.outValid || csiReady;
    if (st.outValid && csiReady) begin
      next_st.outValid = 1'b0;
    end
    if (canOut) begin
      if (!st.inPacket) begin
        sel = fifoOutValid[~st.lastPort] ? ~st.lastPort : st.lastPort; // RULE6
        if (fifoOutValid[sel]) begin
          next_st.inPacket = 1'b1;
          next_st.curPort = sel;
          next_st.hdrDone = 1'b0;
        end
      end else if (fifoOutValid[st.curPort]) begin
        head = dsa_word_t'(fifoOutData[st.curPort]);
        unitValid = 1'b1;
        if (head.sop && !st.hdrDone) begin
          unit = {head.vc, head.dtype, ~{head.vc, head.dtype}}; // RULE7 RULE14
          next_st.hdrDone = 1'b1;
        end else begin
          unit = head.data;
          unitEop = head.eop;
          fifoPop[st.curPort] = 1'b1;
          if (head.eop) begin
            // the packet stays on one port to the end, keeping order within a channel
            next_st.inPacket = 1'b0; // RULE24
            next_st.lastPort = st.curPort;
            next_st.hdrDone = 1'b0;
          end
        end
      end
    end

    // lane packing
    next_st.clkEn = st.outCfg[OCFG_DUAL_BIT] ? 2'h3 : 2'h1; // RULE3
    if (unitValid) begin
      if (st.outCfg[OCFG_DUAL_BIT]) begin
        next_st.outData = {unit, unit}; // RULE2
        next_st.outEn = 4'hf;
        next_st.outValid = 1'b1;
      end else if (st.halfValid) begin
        next_st.outData = {unit, st.half}; // RULE1
        next_st.outEn = 4'hf;
        next_st.outValid = 1'b1;
        next_st.halfValid = 1'b0;
      end else if (unitEop) begin
        next_st.outData = {16'h0000, unit};
        next_st.outEn = 4'h3;
        next_st.outValid = 1'b1;
      end else begin
        next_st.half = unit;
        next_st.halfValid = 1'b1;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
      st.portCfg <= {NUM_PORTS{PORT_CFG_RESET}};
      st.vcRemap <= {NUM_PORTS{VC_REMAP_RESET}};
      st.outCfg <= OUT_CFG_RESET;
      st.clkEn <= 2'h1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign bcOut = st.bcLine;
  assign bcTxReady = st.bcReady;
  assign ctrlRxByte = st.ctrlByte;
  assign ctrlRxValid = st.ctrlValid;
  assign portLocked = st.locked;
  assign regRdData = st.rdData;
  assign csiData = st.outData;
  assign csiByteEn = st.outEn;
  assign csiValid = st.outValid;
  assign csiClkEn = st.clkEn;
endmodule // dsa_aggregator

// ### testbench/dsa_aggregator_assertions.sv
/*
  Port checker of the stream aggregator: output stalls, lanes, clock lanes,
  frame pulses and back channel activity.
  Assumes it is bound to dsa_aggregator and sees one clock domain.
*/
`timescale 1ns/10ps
module dsa_aggregator_assertions (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [1:0] bcOut,
  input wire logic [1:0] bcTxReady,
  input wire logic [1:0] ctrlRxValid,
  input wire logic [1:0] portLocked,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic [31:0] csiData,
  input wire logic [3:0] csiByteEn,
  input wire logic csiValid,
  input wire logic csiReady,
  input wire logic [1:0] csiClkEn
);
  import dsa_pkg::*;
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_rxDone;
    portLocked[0] ##1 !ctrlRxValid[0];
  endsequence
  sequence s_dualOn;
    ##[1:3] csiClkEn == 2'b11;
  endsequence
  AST_VALID_HOLD: assert property (
    csiValid && !csiReady |=> csiValid && $stable(csiData) && $stable(csiByteEn)) else $error("beat changed in stall");
  AST_DUAL_COPY: assert property (
    csiValid && csiClkEn == 2'b11 |-> csiByteEn == 4'hf && csiData[15:0] == csiData[31:16])
    else $error("dual lanes differ");
  AST_CLK0_ON: assert property (
    csiClkEn[0]) else $error("first clock lane off");
  AST_DUAL_CLK: assert property (
    regWrite && regAddr == REG_OUT_CFG && regWrData[OCFG_DUAL_BIT] |-> s_dualOn) else $error("second clock lane off");
  AST_QUAD_EN: assert property (
    csiValid && csiClkEn == 2'b01 |-> csiByteEn == 4'hf || csiByteEn == 4'h3) else $error("bad lane enables");
  AST_RX_PULSE: assert property (
    ctrlRxValid[0] |-> s_rxDone) else $error("frame pulse without lock");
  AST_BC_GAP: assert property (
    $rose(bcTxReady[0]) |=> !bcTxReady[0] [*8]) else $error("back channel words too close");
  AST_BC_LIVE: assert property (
    !bcOut[0] |-> ##[0:250] bcOut[0]) else $error("back channel stuck low");
endmodule // dsa_aggregator_assertions

// ### testbench/dsa_ser_model.sv
/*
  Remote serializer model: sends one forward frame, MSB first.
  Assumes the receiver samples data on the rising link clock edge.
*/
`timescale 1ns/10ps
module dsa_ser_model (
  output logic linkClk,
  output logic linkData
);
  initial begin
    linkClk = 1'b0;
    linkData = 1'b0;
  end
  // clock runs only inside a frame, data changes while clock is low
  task automatic send(input logic [39:0] frame, input int nBits);
    for (int i = nBits - 1; i >= 0; i--) begin
      linkData = frame[i];
      #62.5 linkClk = 1'b1;
      #62.5 linkClk = 1'b0;
    end
    linkData = ~linkData;
  endtask
endmodule // dsa_ser_model

// ### testbench/test_dsa_aggregator.sv
/*
  Top testbench of the aggregator: registers, frames, output, back channel, strap.
  Assumes dsa_pkg, dsa_fifo, dsa_aggregator and dsa_ser_model compiled first.
*/
`timescale 1ns/10ps
module test_dsa_aggregator;
  import dsa_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] linkClk, linkData, bcOut, bcTxReady, ctrlRxValid, portLocked, csiClkEn;
  logic [1:0] bcTxValid = 2'h0;
  logic [1:0][7:0] bcTxByte = '0;
  logic [1:0][7:0] ctrlRxByte;
  logic powerdownReleasePin = 1'b0;
  logic [2:0] strapMode = 3'h0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic regPort = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic csiReady = 1'b0;
  logic csiValid;
  logic [31:0] csiData;
  logic [3:0] csiByteEn;
  int nFail = 0;
  int compares = 0;
  always #5 sys_clk = ~sys_clk;
  dsa_ser_model ser0_u (.linkClk(linkClk[0]), .linkData(linkData[0]));
  dsa_ser_model ser1_u (.linkClk(linkClk[1]), .linkData(linkData[1]));
  dsa_aggregator #(.STRAP_WAIT(20), .DEPTH(FIFO_DEPTH)) dut_u (.sys_clk(sys_clk), .srst(srst),
    .portLinkClk(linkClk), .portLinkData(linkData), .bcOut(bcOut), .bcTxByte(bcTxByte),
    .bcTxValid(bcTxValid), .bcTxReady(bcTxReady), .ctrlRxByte(ctrlRxByte), .ctrlRxValid(ctrlRxValid),
    .portLocked(portLocked), .powerdownReleasePin(powerdownReleasePin), .strapMode(strapMode),
    .regAddr(regAddr), .regPort(regPort), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .csiData(csiData), .csiByteEn(csiByteEn), .csiValid(csiValid),
    .csiReady(csiReady), .csiClkEn(csiClkEn));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      nFail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stopTest();
    $display("compares %0d mismatches %0d", compares, nFail);
    if (nFail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regPort <= p;
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdChk(input string name, input logic p, input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regPort <= p;
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 check(name, 32'(regRdData), 32'(exp));
  endtask
  // waits for a beat, stalls it three cycles, then accepts it
  task automatic getBeat(output logic [31:0] d, output logic [3:0] be);
    int n;
    n = 0;
    @(posedge sys_clk);
    while (csiValid !== 1'b1) begin
      @(posedge sys_clk);
      n++;
      if (n > 3000) begin
        nFail++;
        stopTest();
      end
    end
    repeat (3) @(posedge sys_clk);
    csiReady <= 1'b1;
    @(posedge sys_clk);
    d = csiData;
    be = csiByteEn;
    csiReady <= 1'b0;
  endtask
  function automatic logic [39:0] csiFrame(input logic [1:0] vc, input logic [5:0] dt, input logic [15:0] dat,
    input logic [7:0] ctl);
    logic [39:0] f;
    f = {CSI_SYNC, 1'b1, 1'b1, vc, dt, dat, ctl, 1'b1, 1'b0};
    f[0] = ^f;
    return f;
  endfunction
  // ****************************************
  // scenarios
  // ****************************************
  task automatic tReset();
    rdChk("portCfg", 1'b0, REG_PORT_CFG, PORT_CFG_RESET);
    rdChk("vcRemap", 1'b0, REG_VC_REMAP, VC_REMAP_RESET);
    rdChk("outCfg", 1'b0, REG_OUT_CFG, OUT_CFG_RESET);
    rdChk("unmapped", 1'b0, 8'h00, 8'h00);
    check("clkEnReset", 32'(csiClkEn), 32'h1);
  endtask
  task automatic tCsi();
    logic [31:0] d;
    logic [3:0] be;
    wr(1'b0, REG_VC_REMAP, 8'hec);
    ser0_u.send(csiFrame(2'h1, DTYPE_RAW10, 16'h1234, 8'h5a), 40);
    repeat (10) @(posedge sys_clk);
    check("ctrlByte0", 32'(ctrlRxByte[0]), 32'h5a);
    check("locked0", 32'(portLocked[0]), 32'h1);
    getBeat(d, be);
    check("quadBeat", d, 32'h1234eb14);
    check("quadEn", 32'(be), 32'hf);
  endtask
  task automatic tRaw();
    logic [27:0] f;
    logic [31:0] d;
    logic [3:0] be;
    wr(1'b1, REG_PORT_CFG, 8'h03);
    f = {RAW_SYNC, 1'b1, 1'b1, 12'habc, 8'h3c, 3'h0, 1'b0};
    f[0] = ^f;
    ser1_u.send(40'(f), 28);
    repeat (10) @(posedge sys_clk);
    check("ctrlByte1", 32'(ctrlRxByte[1]), 32'h3c);
    getBeat(d, be);
    check("rawHeader", 32'(d[15:0]), 32'h2bd4);
  endtask
  task automatic tDual();
    logic [31:0] d;
    logic [3:0] be;
    wr(1'b0, REG_OUT_CFG, 8'h01);
    ser0_u.send(csiFrame(2'h0, 6'h12, 16'hbeef, 8'h11), 40);
    getBeat(d, be);
    check("dualHdr", d, 32'h12ed12ed);
    check("clkEnDual", 32'(csiClkEn), 32'h3);
    getBeat(d, be);
    check("dualData", d, 32'hbeefbeef);
    check("dualEn", 32'(be), 32'hf);
    wr(1'b0, REG_OUT_CFG, 8'h00);
  endtask
  task automatic tBc();
    int n;
    logic [11:0] w;
    n = 0;
    bcTxByte[0] <= 8'ha5;
    bcTxValid[0] <= 1'b1;
    @(posedge sys_clk);
    while (bcTxReady[0] !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    bcTxValid[0] <= 1'b0;
    check("bcTaken", 32'(n < 600), 32'h1);
    if (n >= 600) stopTest();
    repeat (15) @(posedge sys_clk);
    for (int i = 11; i >= 0; i--) begin
      w[i] = bcOut[0];
      repeat (10) @(posedge sys_clk);
    end
    check("bcWord", 32'(w), 32'h74b);
  endtask
  task automatic tBad();
    logic [39:0] f;
    f = csiFrame(2'h2, DTYPE_RAW12, 16'h0f0f, 8'h77);
    ser0_u.send({f[39:1], ~f[0]}, 40);
    repeat (10) @(posedge sys_clk);
    check("lockLost", 32'(portLocked[0]), 32'h0);
    check("ctrlKept", 32'(ctrlRxByte[0]), 32'h11);
  endtask
  task automatic tStrap();
    strapMode <= STRAP_RAW12HF;
    powerdownReleasePin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rdChk("strapEarly", 1'b0, REG_PORT_CFG, 8'h00);
    repeat (40) @(posedge sys_clk);
    rdChk("strapPort0", 1'b0, REG_PORT_CFG, 8'h02);
    rdChk("strapPort1", 1'b1, REG_PORT_CFG, 8'h02);
    rdChk("status", 1'b0, REG_STATUS, 8'h12);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    tReset();
    $display("test reset done");
    tCsi();
    $display("test csi done");
    tRaw();
    $display("test raw done");
    tDual();
    $display("test dual done");
    tBc();
    $display("test back channel done");
    tBad();
    $display("test bad frame done");
    tStrap();
    $display("test strap done");
    stopTest();
  end
endmodule // test_dsa_aggregator
bind dsa_aggregator dsa_aggregator_assertions chk_u (.sys_clk(sys_clk), .srst(srst), .bcOut(bcOut),
  .bcTxReady(bcTxReady), .ctrlRxValid(ctrlRxValid), .portLocked(portLocked), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .csiData(csiData), .csiByteEn(csiByteEn),
  .csiValid(csiValid), .csiReady(csiReady), .csiClkEn(csiClkEn));
